// ---- hlpt_pkg.sv ----
// Shared constants and types for the hardware-limit period timer.
package hlpt_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses) and field positions
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_COUNT   = 5'h00;
  localparam logic [4:0] OFS_PERIOD  = 5'h04;
  localparam logic [4:0] OFS_CONTROL = 5'h08;
  localparam logic [4:0] OFS_HWLIMIT = 5'h0c;
  localparam logic [4:0] OFS_STATUS  = 5'h10;

  localparam int unsigned CTL_RUN_BIT    = 7;
  localparam int unsigned CTL_CLKSEL_BIT = 0;
  localparam int unsigned MODE_LSB       = 0;
  localparam int unsigned MODE_W         = 5;

  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [4:0] MODE_RST   = 5'h00;

  // ---------------------------------------------------------------
  // Mode codes
  // ---------------------------------------------------------------
  localparam logic [4:0] M_SW_GATE      = 5'h00;
  localparam logic [4:0] M_GATE_HIGH    = 5'h01;
  localparam logic [4:0] M_GATE_LOW     = 5'h02;
  localparam logic [4:0] M_LIM_ANY      = 5'h03;
  localparam logic [4:0] M_LIM_RISE     = 5'h04;
  localparam logic [4:0] M_LIM_FALL     = 5'h05;
  localparam logic [4:0] M_LVL_RST_LOW  = 5'h06;
  localparam logic [4:0] M_LVL_RST_HIGH = 5'h07;
  localparam logic [4:0] M_SHOT_SW      = 5'h08;
  localparam logic [4:0] M_SHOT_RISE    = 5'h09;
  localparam logic [4:0] M_SHOT_FALL    = 5'h0a;
  localparam logic [4:0] M_SHOT_ANY     = 5'h0b;
  localparam logic [4:0] M_LSHOT_RISE   = 5'h0c;
  localparam logic [4:0] M_LSHOT_FALL   = 5'h0d;
  localparam logic [4:0] M_ESHOT_LOW    = 5'h0e;
  localparam logic [4:0] M_ESHOT_HIGH   = 5'h0f;
  localparam logic [4:0] M_MONO_RISE    = 5'h11;
  localparam logic [4:0] M_MONO_FALL    = 5'h12;
  localparam logic [4:0] M_MONO_ANY     = 5'h13;
  localparam logic [4:0] M_VSHOT_LOW    = 5'h16;
  localparam logic [4:0] M_VSHOT_HIGH   = 5'h17;

  // ---------------------------------------------------------------
  // Timing counts, in timer clocks or system clocks
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_TICKS     = 2;
  localparam int unsigned RESTART_TICKS  = 2;
  localparam logic [1:0]  RESTART_HOLD   = 2'(RESTART_TICKS - 1);
  localparam int unsigned INT_DIV_DEFAULT = 2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } hlpt_state_t;

  typedef struct packed {
    logic [4:0] addr;
    logic       write;
  } hlpt_req_t;

endpackage : hlpt_pkg

// ---- hlpt_timer.sv ----
// Hardware-limit period timer with AHB-Lite register slave.
`timescale 1ns/1ps

// How it works
// - After run bit is cleared, edge-start modes need a fresh edge to start.
// - One-shot match: next timer clock clears run bit, counter stops at zero.
// - Monostable match: next timer clock stops counter at zero, run bit kept.
// - Software gate counts while run bit set, wraps to zero after match.
// - Hardware gate also gates on external signal; 00001 high, 00010 low.
// - Edge hardware limit resets counter on any, rising or falling edge.
// - After an early edge reset counting restarts two timer clocks later.
// - Level hardware limit holds counter reset while signal at chosen level.
// - Level hardware limit ignores the external signal while run bit is zero.
// - Level limit resets on match or held level; resumes after release.
// - Software one-shot clears run bit on match; software must set it again.
// - Edge one-shot starts on selected edge after run bit set; match clears.
// - Edge one-shot halted by run bit clear needs a new edge to resume.
// - Edge limit one-shot: first edge starts, later edges reset then resume.
// - Edge limit one-shot match clears run bit; edges ignored until set.
// - Level-reset one-shot holds reset at level, starts on edge to active (01110/01111) or on release (10110/10111).
// - Level-reset one-shot match clears run bit; restart needs a new edge for 01110/01111 only.
// - Run bit and external signal pass two timer clocks of synchronisation.
// - A five-bit mode field selects family by code range, variant within the range.
// - Clearing the run bit returns mode state machines to their idle state.
module hlpt_timer #(
  parameter int unsigned INT_DIV = hlpt_pkg::INT_DIV_DEFAULT
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  input  wire logic        TIMER_CLOCK_IN,
  input  wire logic        EXT_RESET_TRIGGER_IN,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic      [7:0]  COUNT_VALUE,
  output logic             POSTSCALED_MATCH,
  output logic             TIMER_RUNNING
);

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  logic [1:0]              pin_raw;
  logic [2:0]              sync_q [0:1];
  logic [1:0]              pin_lvl_q;
  logic                    tclk_prev_q;
  logic [7:0]              div_q;
  logic                    div_tick;
  logic                    ext_tick;
  logic                    tick;
  hlpt_pkg::hlpt_req_t     req_q;
  logic                    pend_q;
  logic                    accept;
  logic                    wr_en;
  logic                    wr_count;
  logic                    wr_period;
  logic                    wr_ctl;
  logic                    wr_mode;
  logic [31:0]             rd_mux;
  logic [7:0]              cnt_q;
  logic [7:0]              cnt_d;
  logic [7:0]              period_q;
  logic [4:0]              mode_q;
  logic                    on_q;
  logic                    clksel_q;
  logic                    on_t1_q;
  logic                    on_t2_q;
  logic                    ers_t1_q;
  logic                    ers_t2_q;
  logic                    ers_t3_q;
  hlpt_pkg::hlpt_state_t   st_q;
  hlpt_pkg::hlpt_state_t   st_d;
  logic [1:0]              hold_q;
  logic [1:0]              hold_d;
  logic                    clr_on;
  logic                    match;
  logic                    rise;
  logic                    fall;
  logic                    is_gate;
  logic                    gate_ok;
  logic                    is_lim;
  logic                    is_lvl;
  logic                    lvl_rst;
  logic                    is_free;
  logic                    is_sw_shot;
  logic                    is_lshot;
  logic                    is_eshot;
  logic                    is_vshot;
  logic                    is_mono;
  logic                    is_edge_start;
  logic                    valid_mode;
  logic                    clears_on;
  logic                    shot_lvl_rst;
  logic                    start_hit;
  logic                    lim_edge_hit;
  logic                    start_cond;

  // Address decode shared by the write strobes and the read mux.
  function automatic logic reg_hit(input logic [4:0] a,
                                   input logic [4:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  // Mode set membership, used by every mode-class decode except is_sw_shot.
  function automatic logic mode_in(input logic [4:0] m,
                                   input logic [4:0] lo,
                                   input logic [4:0] hi);
    mode_in = (m >= lo) && (m <= hi);
  endfunction : mode_in

  // -----------------------------------------------------------------
  // Pin synchronisers: three stages, level taken when stages 2 and 3 agree
  // -----------------------------------------------------------------
  assign pin_raw = {EXT_RESET_TRIGGER_IN, TIMER_CLOCK_IN};

  for (genvar g = 0; g < 2; g++) begin : g_sync
    // Stage 1 feeds only stage 2; the filtered level follows 2 and 3.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
        sync_q[g]    <= 3'h0;
        pin_lvl_q[g] <= 1'b0;
      end else begin
        sync_q[g] <= {sync_q[g][1:0], pin_raw[g]};
        if (sync_q[g][1] == sync_q[g][2]) begin
          pin_lvl_q[g] <= sync_q[g][2];
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Timer tick: external clock rising edge or internal divider
  // -----------------------------------------------------------------
  assign div_tick = (div_q == 8'(INT_DIV - 1));
  assign ext_tick = pin_lvl_q[0] & ~tclk_prev_q;
  assign tick     = clksel_q ? div_tick : ext_tick;

  // Divider makes a one-cycle enable; edge history for the pin clock.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_q       <= 8'h00;
      tclk_prev_q <= 1'b0;
    end else begin
      div_q       <= div_tick ? 8'h00 : div_q + 8'h01;
      tclk_prev_q <= pin_lvl_q[0];
    end
  end

  // -----------------------------------------------------------------
  // AHB-Lite slave: one wait state, always OKAY
  // -----------------------------------------------------------------
  assign accept    = HSEL & HTRANS[1] & HREADY;
  assign wr_en     = pend_q & req_q.write;
  assign wr_count  = wr_en & reg_hit(req_q.addr, hlpt_pkg::OFS_COUNT);
  assign wr_period = wr_en & reg_hit(req_q.addr, hlpt_pkg::OFS_PERIOD);
  assign wr_ctl    = wr_en & reg_hit(req_q.addr, hlpt_pkg::OFS_CONTROL);
  assign wr_mode   = wr_en & reg_hit(req_q.addr, hlpt_pkg::OFS_HWLIMIT);

  // Read mux; unmapped offsets read as zero.
  assign rd_mux =
    reg_hit(req_q.addr, hlpt_pkg::OFS_COUNT)   ? {24'h000000, cnt_q}    :
    reg_hit(req_q.addr, hlpt_pkg::OFS_PERIOD)  ? {24'h000000, period_q} :
    reg_hit(req_q.addr, hlpt_pkg::OFS_CONTROL) ?
      {24'h000000, on_q, 6'h00, clksel_q} :
    reg_hit(req_q.addr, hlpt_pkg::OFS_HWLIMIT) ? {27'h0000000, mode_q}  :
    reg_hit(req_q.addr, hlpt_pkg::OFS_STATUS)  ?
      {28'h0000000, (hold_q != 2'h0), on_t2_q,
       (st_q == hlpt_pkg::ST_RUN), ers_t2_q} :
    32'h00000000;

  // Address phase is latched, the data phase completes one cycle later.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      req_q     <= '0;
      pend_q    <= 1'b0;
      HREADYOUT <= 1'b1;
      HRDATA    <= 32'h00000000;
      HRESP     <= 1'b0;
    end else if (accept) begin
      req_q     <= '{addr: HADDR[4:0], write: HWRITE};
      pend_q    <= 1'b1;
      HREADYOUT <= 1'b0;
    end else if (pend_q) begin
      pend_q    <= 1'b0;
      HREADYOUT <= 1'b1;
      HRDATA    <= req_q.write ? 32'h00000000 : rd_mux;
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      period_q <= hlpt_pkg::PERIOD_RST;
      mode_q   <= hlpt_pkg::MODE_RST;
      clksel_q <= 1'b0;
    end else begin
      if (wr_period) period_q <= HWDATA[7:0];
      if (wr_mode) begin
        mode_q <= HWDATA[hlpt_pkg::MODE_LSB +: hlpt_pkg::MODE_W];
      end
      if (wr_ctl) clksel_q <= HWDATA[hlpt_pkg::CTL_CLKSEL_BIT];
    end
  end

  // Run bit: a software write wins over the hardware clear.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      on_q <= 1'b0;
    end else if (wr_ctl) begin
      on_q <= HWDATA[hlpt_pkg::CTL_RUN_BIT];
    end else if (tick && clr_on) begin
      on_q <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Timer-clock synchronisation of the run bit and external signal
  // -----------------------------------------------------------------
  // Two timer clocks of delay; a hardware clear also flushes the run pipe.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      on_t1_q  <= 1'b0;
      on_t2_q  <= 1'b0;
      ers_t1_q <= 1'b0;
      ers_t2_q <= 1'b0;
      ers_t3_q <= 1'b0;
    end else if (tick) begin
      on_t1_q  <= on_q & ~clr_on;
      on_t2_q  <= on_t1_q & ~clr_on;
      ers_t1_q <= pin_lvl_q[1];
      ers_t2_q <= ers_t1_q;
      ers_t3_q <= ers_t2_q;
    end
  end

  // -----------------------------------------------------------------
  // Mode decode
  // -----------------------------------------------------------------
  assign match = (cnt_q == period_q);
  assign rise  = ers_t2_q & ~ers_t3_q;
  assign fall  = ~ers_t2_q & ers_t3_q;

  assign is_gate = mode_in(mode_q, hlpt_pkg::M_SW_GATE,
                           hlpt_pkg::M_GATE_LOW);
  assign is_lim  = mode_in(mode_q, hlpt_pkg::M_LIM_ANY,
                           hlpt_pkg::M_LIM_FALL);
  assign is_lvl  = mode_in(mode_q, hlpt_pkg::M_LVL_RST_LOW,
                           hlpt_pkg::M_LVL_RST_HIGH);
  assign is_free = is_gate | is_lim | is_lvl;
  assign is_sw_shot = (mode_q == hlpt_pkg::M_SHOT_SW);
  assign is_lshot = mode_in(mode_q, hlpt_pkg::M_LSHOT_RISE,
                            hlpt_pkg::M_LSHOT_FALL);
  assign is_eshot = mode_in(mode_q, hlpt_pkg::M_ESHOT_LOW,
                            hlpt_pkg::M_ESHOT_HIGH);
  assign is_vshot = mode_in(mode_q, hlpt_pkg::M_VSHOT_LOW,
                            hlpt_pkg::M_VSHOT_HIGH);
  assign is_mono  = mode_in(mode_q, hlpt_pkg::M_MONO_RISE,
                            hlpt_pkg::M_MONO_ANY);
  assign is_edge_start = mode_in(mode_q, hlpt_pkg::M_SHOT_RISE,
                                 hlpt_pkg::M_ESHOT_HIGH) | is_mono;
  assign valid_mode = is_free | is_sw_shot | is_edge_start | is_vshot;
  assign clears_on  = valid_mode & ~is_free & ~is_mono;

  // Gate qualifier for hardware gate modes.
  assign gate_ok = (mode_q == hlpt_pkg::M_GATE_HIGH) ? ers_t2_q :
                   (mode_q == hlpt_pkg::M_GATE_LOW)  ? ~ers_t2_q :
                   1'b1;

  // Level reset for the free-running level limit modes.
  assign lvl_rst = (mode_q == hlpt_pkg::M_LVL_RST_LOW  & ~ers_t2_q) |
                   (mode_q == hlpt_pkg::M_LVL_RST_HIGH &  ers_t2_q);

  // Reset level for the level-reset one-shot families.
  assign shot_lvl_rst =
    ((mode_q == hlpt_pkg::M_ESHOT_LOW  ||
      mode_q == hlpt_pkg::M_VSHOT_LOW)  && !ers_t2_q) ||
    ((mode_q == hlpt_pkg::M_ESHOT_HIGH ||
      mode_q == hlpt_pkg::M_VSHOT_HIGH) &&  ers_t2_q);

  // Start edge selection for edge-started one-shot and monostable modes.
  assign start_hit =
    (rise & (mode_q == hlpt_pkg::M_SHOT_RISE  ||
             mode_q == hlpt_pkg::M_LSHOT_RISE ||
             mode_q == hlpt_pkg::M_ESHOT_LOW  ||
             mode_q == hlpt_pkg::M_MONO_RISE)) |
    (fall & (mode_q == hlpt_pkg::M_SHOT_FALL  ||
             mode_q == hlpt_pkg::M_LSHOT_FALL ||
             mode_q == hlpt_pkg::M_ESHOT_HIGH ||
             mode_q == hlpt_pkg::M_MONO_FALL)) |
    ((rise | fall) & (mode_q == hlpt_pkg::M_SHOT_ANY ||
                      mode_q == hlpt_pkg::M_MONO_ANY));

  // Early reset edge for the edge hardware limit modes.
  assign lim_edge_hit =
    ((rise | fall) & (mode_q == hlpt_pkg::M_LIM_ANY)) |
    (rise & (mode_q == hlpt_pkg::M_LIM_RISE ||
             mode_q == hlpt_pkg::M_LSHOT_RISE)) |
    (fall & (mode_q == hlpt_pkg::M_LIM_FALL ||
             mode_q == hlpt_pkg::M_LSHOT_FALL));

  assign start_cond = is_sw_shot | (is_edge_start & start_hit) |
                      (is_vshot & ~shot_lvl_rst);

  // -----------------------------------------------------------------
  // Counter and mode state machine, next values per timer clock
  // -----------------------------------------------------------------
  always_comb begin
    cnt_d  = cnt_q;
    st_d   = st_q;
    hold_d = hold_q;
    clr_on = 1'b0;
    if (!valid_mode) begin
      cnt_d  = 8'h00;
      st_d   = hlpt_pkg::ST_IDLE;
      hold_d = 2'h0;
    end else if (!on_t2_q) begin
      st_d   = hlpt_pkg::ST_IDLE;
      hold_d = 2'h0;
    end else if (is_free) begin
      if (is_lvl && lvl_rst) begin
        cnt_d = 8'h00;
      end else if (is_lim && lim_edge_hit) begin
        cnt_d  = 8'h00;
        hold_d = hlpt_pkg::RESTART_HOLD;
      end else if (hold_q != 2'h0) begin
        hold_d = hold_q - 2'h1;
      end else if (gate_ok) begin
        cnt_d = match ? 8'h00 : cnt_q + 8'h01;
      end
    end else begin
      case (st_q)
        hlpt_pkg::ST_IDLE: begin
          if (shot_lvl_rst) begin
            cnt_d = 8'h00;
          end else if (start_cond) begin
            st_d = hlpt_pkg::ST_RUN;
          end
        end
        hlpt_pkg::ST_RUN: begin
          if (shot_lvl_rst) begin
            cnt_d = 8'h00;
            st_d  = hlpt_pkg::ST_IDLE;
          end else if (match) begin
            cnt_d  = 8'h00;
            st_d   = hlpt_pkg::ST_IDLE;
            clr_on = clears_on;
          end else if (is_lshot && lim_edge_hit) begin
            cnt_d  = 8'h00;
            hold_d = hlpt_pkg::RESTART_HOLD;
          end else if (hold_q != 2'h0) begin
            hold_d = hold_q - 2'h1;
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end
        default: begin
          st_d = hlpt_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Timer state; a software write to the counter takes priority.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q  <= hlpt_pkg::COUNT_RST;
      st_q   <= hlpt_pkg::ST_IDLE;
      hold_q <= 2'h0;
    end else begin
      if (wr_count) begin
        cnt_q <= HWDATA[7:0];
      end else if (tick) begin
        cnt_q <= cnt_d;
      end
      if (tick) begin
        st_q   <= st_d;
        hold_q <= hold_d;
      end
    end
  end

  // Registered outputs toward the time-base user.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      COUNT_VALUE      <= 8'h00;
      POSTSCALED_MATCH <= 1'b0;
      TIMER_RUNNING    <= 1'b0;
    end else begin
      COUNT_VALUE      <= cnt_q;
      POSTSCALED_MATCH <= tick & on_t2_q & valid_mode & match;
      TIMER_RUNNING    <= on_t2_q & (is_free | (st_q == hlpt_pkg::ST_RUN));
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  a_sw_gate_count: assert property (
    (tick && on_t2_q && mode_q == hlpt_pkg::M_SW_GATE && !wr_count)
    |=> cnt_q == ($past(match) ? 8'h00 : 8'($past(cnt_q) + 8'h01)))
    else $error("software gate count step wrong");

  a_hw_gate_hold: assert property (
    (tick && mode_q == hlpt_pkg::M_GATE_HIGH && !ers_t2_q && !wr_count)
    |=> $stable(cnt_q))
    else $error("hardware gate did not hold the count");

  a_edge_restart: assert property (
    (tick && on_t2_q && is_lim && lim_edge_hit && !wr_count)
    |=> cnt_q == 8'h00 && hold_q == hlpt_pkg::RESTART_HOLD)
    else $error("edge reset did not zero and hold the count");

  a_level_reset: assert property (
    (tick && on_t2_q && mode_q == hlpt_pkg::M_LVL_RST_HIGH && ers_t2_q
     && !wr_count) |=> cnt_q == 8'h00)
    else $error("level reset did not clear the count");

  a_oneshot_done: assert property (
    (tick && on_t2_q && clears_on && st_q == hlpt_pkg::ST_RUN && match
     && !shot_lvl_rst && !wr_ctl && !wr_count)
    |=> cnt_q == 8'h00 && !on_q && st_q == hlpt_pkg::ST_IDLE)
    else $error("one-shot match did not stop and clear run");

  a_mono_keep_on: assert property (
    (tick && on_t2_q && is_mono && st_q == hlpt_pkg::ST_RUN && match
     && on_q && !wr_ctl && !wr_count)
    |=> cnt_q == 8'h00 && on_q && st_q == hlpt_pkg::ST_IDLE)
    else $error("monostable match changed run bit or count");

  a_off_idle: assert property (
    (tick && !on_t2_q) |=> st_q == hlpt_pkg::ST_IDLE && hold_q == 2'h0)
    else $error("mode state not idle while run bit clear");

  a_reserved_zero: assert property (
    (tick && !valid_mode && !wr_count) |=> cnt_q == 8'h00)
    else $error("reserved mode did not hold count at zero");

  a_ahb_wait: assert property (
    accept |=> !HREADYOUT ##1 HREADYOUT && !HRESP)
    else $error("bus answer timing wrong");

endmodule : hlpt_timer

// ---- hlpt_ext_src.sv ----
// Far-side model: timer clock source and external reset signal source.
`timescale 1ns/1ps
module hlpt_ext_src (
  input  wire logic SYS_CLK,
  input  wire logic RST_N,
  input  wire logic level_req,
  output logic      timer_clk,
  output logic      ext_lvl
);
  logic [1:0] div_q;
  logic [3:0] gap_q;
  // A free timer clock of four system cycles; level changes keep spacing.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_q   <= 2'h0;
      gap_q   <= 4'h0;
      ext_lvl <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        if (gap_q != 4'hf) gap_q <= gap_q + 4'h1;
        if (level_req != ext_lvl && gap_q >= 4'h6) begin
          ext_lvl <= level_req;
          gap_q   <= 4'h0;
        end
      end
    end
  end
  assign timer_clk = div_q[1];
endmodule : hlpt_ext_src

// ---- test_hlpt_timer.sv ----
// Self-checking testbench for the hardware-limit period timer.
`timescale 1ns/1ps
module test_hlpt_timer;
  logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, lvl = 0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        hready, hresp, match, running, tclk, ext;
  logic [7:0]  cnt, maxv;
  int          err_count = 0, check_count = 0, cyc = 0, nch, npm;
  // Clock at 50 MHz and a ceiling on the run length.
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  hlpt_timer hlpt_timer_inst (.SYS_CLK(clk), .RST_N(rst_n), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .TIMER_CLOCK_IN(tclk),
    .EXT_RESET_TRIGGER_IN(ext), .HRDATA(hrdata), .HREADYOUT(hready),
    .HRESP(hresp), .COUNT_VALUE(cnt), .POSTSCALED_MATCH(match),
    .TIMER_RUNNING(running));
  hlpt_ext_src hlpt_ext_src_inst (.SYS_CLK(clk), .RST_N(rst_n),
    .level_req(lvl), .timer_clk(tclk), .ext_lvl(ext));
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task ahb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {27'h0, a}; hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task run(input logic [4:0] m);
    ahb(1'b1, hlpt_pkg::OFS_COUNT, 32'h0);
    ahb(1'b1, hlpt_pkg::OFS_PERIOD, 32'h5);
    ahb(1'b1, hlpt_pkg::OFS_HWLIMIT, {27'h0, m});
    ahb(1'b1, hlpt_pkg::OFS_CONTROL, 32'h80);
  endtask : run
  task setx(input logic v);
    @(posedge clk) lvl <= v;
    while (ext !== v) @(posedge clk);
    repeat (16) @(posedge clk);
  endtask : setx
  // Follows the counter; each step is +1 or a wrap after the period.
  // Match pulses last one cycle, so they are counted at each falling edge.
  task watch(input int n);
    logic [7:0] prv;
    prv = cnt; nch = 0; maxv = cnt; npm = 0;
    repeat (n) begin
      @(negedge clk);
      if (match === 1'b1) npm++;
      if (cnt !== prv) begin
        nch++;
        chk(cnt == prv + 8'h1 || (prv == 8'h5 && cnt == 8'h0), 1);
        prv = cnt;
      end
      if (cnt > maxv) maxv = cnt;
    end
  endtask : watch
  task t_regs();
    ahb(1'b0, hlpt_pkg::OFS_PERIOD, 0); chk(rd, 32'hff);
    ahb(1'b0, hlpt_pkg::OFS_HWLIMIT, 0); chk(rd, 32'h0);
    ahb(1'b0, 5'h14, 0); chk(rd, 32'h0);
    chk(hresp, 1'b0);
    $display("registers done");
  endtask : t_regs
  task t_swgate();
    run(hlpt_pkg::M_SW_GATE);
    watch(200); chk(maxv, 8'h5); chk(nch >= 10, 1);
    chk(npm >= 5, 1); chk(running, 1);
    ahb(1'b1, hlpt_pkg::OFS_CONTROL, 0);
    watch(20); watch(60); chk(nch, 0);
    $display("software gate done");
  endtask : t_swgate
  task t_gates();
    logic [4:0] m[4];
    m = '{hlpt_pkg::M_GATE_HIGH, hlpt_pkg::M_GATE_LOW,
          hlpt_pkg::M_LVL_RST_LOW, hlpt_pkg::M_LVL_RST_HIGH};
    for (int i = 0; i < 4; i++) begin
      setx(i[0]); run(m[i]);
      watch(80); chk(nch, 0);
      setx(!i[0]);
      watch(80); chk(nch >= 5, 1);
      ahb(1'b1, hlpt_pkg::OFS_CONTROL, 0);
    end
    $display("gate and level modes done");
  endtask : t_gates
  task t_shot();
    run(hlpt_pkg::M_SHOT_SW); watch(200);
    chk(maxv, 8'h5); chk(npm, 1);
    ahb(1'b0, hlpt_pkg::OFS_CONTROL, 0); chk(rd[7], 0);
    chk(cnt, 8'h0); chk(running, 0);
    $display("software one-shot done");
  endtask : t_shot
  task t_edge();
    setx(1'b0); run(hlpt_pkg::M_SHOT_RISE);
    watch(80); chk(nch, 0);
    setx(1'b1); watch(200); chk(maxv, 8'h5);
    ahb(1'b0, hlpt_pkg::OFS_CONTROL, 0); chk(rd[7], 0);
    run(hlpt_pkg::M_SHOT_RISE); watch(80); chk(nch, 0);
    ahb(1'b1, hlpt_pkg::OFS_CONTROL, 0);
    $display("edge one-shot done");
  endtask : t_edge
  // A long period lets a rising edge cut the count short.
  task t_lim();
    setx(1'b0); run(hlpt_pkg::M_LIM_RISE);
    ahb(1'b1, hlpt_pkg::OFS_PERIOD, 32'hff);
    watch(80); chk(cnt > 8'h8, 1);
    setx(1'b1); repeat (8) @(posedge clk);
    chk(cnt < 8'h3, 1);
    ahb(1'b1, hlpt_pkg::OFS_CONTROL, 0);
    $display("edge limit done");
  endtask : t_lim
  // Monostable keeps the run bit after a match and restarts on an edge.
  task t_mono();
    setx(1'b0); run(hlpt_pkg::M_MONO_RISE);
    setx(1'b1); watch(200); chk(maxv, 8'h5);
    ahb(1'b0, hlpt_pkg::OFS_CONTROL, 0); chk(rd[7], 1);
    setx(1'b0); setx(1'b1); watch(120); chk(nch >= 4, 1);
    ahb(1'b1, hlpt_pkg::OFS_CONTROL, 0);
    $display("monostable done");
  endtask : t_mono
  task t_rsv();
    run(5'h18); watch(100); chk(nch, 0);
    ahb(1'b1, hlpt_pkg::OFS_COUNT, 32'h3);
    repeat (12) @(posedge clk);
    chk(cnt, 8'h0);
    ahb(1'b1, hlpt_pkg::OFS_CONTROL, 0);
    $display("reserved mode done");
  endtask : t_rsv
  task stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // Reset for eight cycles, then the scenarios in turn.
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs(); t_swgate(); t_gates(); t_shot(); t_edge(); t_lim(); t_mono();
    t_rsv();
    stop_test();
  end
endmodule : test_hlpt_timer
